// [uefr_top.sv]
// Extended feature, status and trigger registers of one UART channel.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`default_nettype none

module uefr_top
#(
   parameter logic [7:0] REVISION = 8'h0001,  // Arbitrary value.
   parameter logic [7:0] DEVICE_ID = 8'h005A  // Arbitrary value.
)
(
   input  wire  logic               mclk,
   input  wire  logic               rst,
   input  wire  uefr_pkg::uefr_bus_t bus,
   output var   logic [7:0]         rdata,
   input  wire  logic [7:0]         line_control_reg,
   input  wire  logic [7:0]         divisor_low_byte,
   input  wire  logic [7:0]         divisor_high_byte,
   input  wire  logic               enhanced_feature_bit4,
   input  wire  logic               modem_control_bit3,
   input  wire  logic               baud_clock_output,
   input  wire  logic [6:0]         rx_fifo_count,
   input  wire  logic [6:0]         tx_fifo_count,
   output var   logic [7:0]         second_stop_character,
   output var   logic [6:0]         receive_trigger_level,
   output var   logic [6:0]         transmit_trigger_level,
   output var   logic [1:0]         trigger_table,
   output var   logic [5:0]         rts_hysteresis,
   output var   logic               multi_function_output,
   output var   logic               rs485_access_en,
   output var   logic               tx_disable,
   output var   logic               rx_disable,
   output var   logic               ir_fast_mode,
   output var   logic               ir_rx_invert,
   output var   logic               sample_clock_access_en,
   output var   logic               fifo_ready_access_dis
);
   import uefr_pkg::*;

   //---------------------------------------------------------------------
   // Address decode
   //---------------------------------------------------------------------
   logic [7:0] second_stop_character_reg;
   logic [6:0] rx_trig_reg;
   logic [6:0] tx_trig_reg;
   logic [5:0] feature_control_reg;
   logic       afr_reg;
   uefr_asr_t  asr_reg;
   logic       fc_sel_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic       mfo_reg;
   logic [5:0] hyst_reg;

   wire key_mode  = (line_control_reg == LCR_ENH_KEY);
   wire dlab_mode = line_control_reg[LCR_DLAB_BIT] && !key_mode;
   wire dll_zero  = (divisor_low_byte == DIV_ZERO);
   wire dlm_zero  = (divisor_high_byte == DIV_ZERO);

   wire sel_second_stop_character = key_mode && (bus.addr == OFS_SECOND_STOP_CHARACTER);       // [RULE1]
   wire sel_trgfc = key_mode && (bus.addr == OFS_TRG_FC);
   wire sel_feature_control  = key_mode && (bus.addr == OFS_FEATURE_CONTROL);
   wire sel_rev   = dlab_mode && dll_zero
                    && (bus.addr == OFS_REV);                   // [RULE2]
   wire sel_devid = dlab_mode && dll_zero && dlm_zero
                    && (bus.addr == OFS_DEVID);                 // [RULE3]
   wire sel_afr   = dlab_mode && !enhanced_feature_bit4
                    && (bus.addr == OFS_AFR);                   // [RULE12]
   wire sel_asr   = dlab_mode && enhanced_feature_bit4
                    && (bus.addr == OFS_ASR);                   // [RULE14]

   wire wr_second_stop_character  = bus.wr && sel_second_stop_character;
   wire wr_trg    = bus.wr && sel_trgfc;
   wire wr_feature_control   = bus.wr && sel_feature_control;
   wire wr_afr    = bus.wr && sel_afr;
   wire wr_asr    = bus.wr && sel_asr;
   // Offset zero under the key is the level counter for reads only; the
   // trigger register behind it never answers a read.
   wire rd_fc     = bus.rd && sel_trgfc;                        // [RULE5]

   wire trg_to_tx = bus.wdata[TRG_SEL_BIT];                     // [RULE4]
   wire [6:0] fc_count = fc_sel_reg ? tx_fifo_count : rx_fifo_count;

   // Reserved feature control and alternate function bits are not stored, so they read as zero.
   wire [7:0] feature_control_view = {2'b00, feature_control_reg};                   // [RULE22]
   wire [7:0] afr_view  = {6'b00_0000, afr_reg, 1'b0};         // [RULE22]

   always_comb
   begin
      rdata_next = 8'h0000;
      if (bus.rd)
      begin
         if (sel_second_stop_character)
            rdata_next = second_stop_character_reg;
         else if (sel_trgfc)
            rdata_next = {fc_sel_reg, fc_count};                // [RULE6]
         else if (sel_feature_control)
            rdata_next = feature_control_view;
         else if (sel_rev)
            rdata_next = REVISION;
         else if (sel_devid)
            rdata_next = DEVICE_ID;
         else if (sel_afr)
            rdata_next = afr_view;
         else if (sel_asr)
            rdata_next = asr_reg;
         else
            rdata_next = 8'h0000;
      end
   end

   //---------------------------------------------------------------------
   // Storage
   //---------------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         second_stop_character_reg <= SECOND_STOP_CHARACTER_RESET;
         feature_control_reg  <= FEATURE_CONTROL_RESET;
         afr_reg   <= AFR_RESET;
         asr_reg   <= ASR_RESET;
      end
      else
      begin
         if (wr_second_stop_character)
            second_stop_character_reg <= bus.wdata;                             // [RULE1]
         if (wr_feature_control)
            feature_control_reg <= bus.wdata[5:0];                         // [RULE8]
         if (wr_afr)
            afr_reg <= bus.wdata[AFR_OP2_BIT];
         if (wr_asr)
            asr_reg <= bus.wdata;                               // [RULE14]
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rx_trig_reg <= TRIG_RESET;
         tx_trig_reg <= TRIG_RESET;
      end
      else if (wr_trg && trg_to_tx)
         tx_trig_reg <= bus.wdata[6:0];                         // [RULE4]
      else if (wr_trg)
         rx_trig_reg <= bus.wdata[6:0];                         // [RULE4]
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         fc_sel_reg <= 1'b0;
      else if (rd_fc)
         fc_sel_reg <= !fc_sel_reg;                             // [RULE7]
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         rdata_reg <= 8'h0000;
      else
         rdata_reg <= rdata_next;
   end

   //---------------------------------------------------------------------
   // Derived outputs
   //---------------------------------------------------------------------
   // Hysteresis is forced to zero unless the fourth table is chosen.
   // It is taken from the value being stored, so that the hysteresis
   // and the table selection change on the same edge.
   wire [5:0] feature_control_next = wr_feature_control ? bus.wdata[5:0] : feature_control_reg;
   wire rx_table_d = (feature_control_next[5:4] == TABLE_D);               // [RULE9]
   wire [5:0] hyst_next = rx_table_d ?
                          HYST_TABLE[feature_control_next[3:0]] : 6'd0;    // [RULE10]
   // The source is chosen before the flop, so the pin lags by one cycle.
   wire mfo_next = afr_reg ? baud_clock_output
                           : !modem_control_bit3;               // [RULE13]

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         hyst_reg <= 6'd0;
         mfo_reg  <= 1'b1;
      end
      else
      begin
         hyst_reg <= hyst_next;                                 // [RULE11]
         mfo_reg  <= mfo_next;
      end
   end

   assign rdata                  = rdata_reg;
   assign second_stop_character  = second_stop_character_reg;
   assign receive_trigger_level  = rx_trig_reg;
   assign transmit_trigger_level = tx_trig_reg;
   assign trigger_table          = feature_control_reg[5:4];               // [RULE8]
   assign rts_hysteresis         = hyst_reg;
   assign multi_function_output  = mfo_reg;
   assign rs485_access_en        = asr_reg.rs485_acc;           // [RULE15]
   assign tx_disable             = asr_reg.tx_dis;              // [RULE16]
   assign rx_disable             = asr_reg.rx_dis;              // [RULE17]
   assign ir_fast_mode           = asr_reg.ir_fast;             // [RULE18]
   assign ir_rx_invert           = asr_reg.ir_inv;              // [RULE19]
   assign sample_clock_access_en = asr_reg.sclk_acc;            // [RULE20]
   assign fifo_ready_access_dis  = asr_reg.fready_dis;          // [RULE21]

   //---------------------------------------------------------------------
   // Assertions
   //---------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_tx_trig_write;
      wr_trg && trg_to_tx;
   endsequence

   sequence s_fc_read;
      rd_fc;
   endsequence

   sequence s_rx_trig_write;
      wr_trg && !trg_to_tx;
   endsequence

   sequence s_asr_write;
      wr_asr;
   endsequence

   // The pin carries its reset level through the release edge, so the
   // source checks start only once reset was low at the sampling edge.

   chk_second_stop_character_write: assert property ( // [RULE1]
      wr_second_stop_character |=> second_stop_character == $past(bus.wdata))
      else $error("second stop character not stored");

   chk_rev_read: assert property ( // [RULE2]
      bus.rd && sel_rev |=> rdata == REVISION)
      else $error("revision read wrong");

   chk_devid_read: assert property ( // [RULE3]
      bus.rd && sel_devid |=> rdata == DEVICE_ID)
      else $error("device identification read wrong");

   chk_trg_target: assert property ( // [RULE4]
      s_tx_trig_write |=> transmit_trigger_level == $past(bus.wdata[6:0])
                          && $stable(receive_trigger_level))
      else $error("trigger write reached wrong level");

   chk_fc_content: assert property ( // [RULE6]
      s_fc_read |=> rdata[FC_SEL_BIT] == $past(fc_sel_reg)
                    && rdata[6:0] == $past(fc_count))
      else $error("level counter read wrong");

   chk_fc_alternate: assert property ( // [RULE7]
      s_fc_read |=> fc_sel_reg != $past(fc_sel_reg))
      else $error("level counter did not alternate");

   chk_hyst_gate: assert property ( // [RULE9]
      !rx_table_d |=> rts_hysteresis == 6'd0)
      else $error("hysteresis active outside fourth table");

   chk_afr_lock: assert property ( // [RULE12]
      bus.wr && !sel_afr |=> $stable(afr_reg))
      else $error("alternate function changed while locked");

   chk_asr_lock: assert property ( // [RULE14]
      bus.wr && !sel_asr |=> $stable(asr_reg))
      else $error("advanced special changed while locked");

   chk_op2_source: assert property ( // [RULE13]
      !rst && !afr_reg
      |=> multi_function_output == !$past(modem_control_bit3))
      else $error("multi-function output source wrong");

   chk_tx_disable: assert property ( // [RULE16]
      s_asr_write |=> tx_disable == $past(bus.wdata[6]))
      else $error("transmitter disable not set");

   chk_reserved_zero: assert property ( // [RULE22]
      bus.rd && sel_feature_control |=> rdata[7:6] == 2'b00)
      else $error("reserved feature control bits not zero");

   chk_second_stop_character_hold: assert property ( // [RULE1]
      !wr_second_stop_character |=> $stable(second_stop_character))
      else $error("second stop character changed without write");

   chk_second_stop_character_read: assert property ( // [RULE1]
      bus.rd && sel_second_stop_character |=> rdata == $past(second_stop_character))
      else $error("second stop character read wrong");

   chk_rev_hidden: assert property ( // [RULE2]
      bus.rd && dlab_mode && !dll_zero && bus.addr == OFS_REV
      |=> rdata == 8'h00)
      else $error("revision visible with divisor set");

   chk_devid_hidden: assert property ( // [RULE3]
      bus.rd && !key_mode && !(dll_zero && dlm_zero)
      && bus.addr == OFS_DEVID |=> rdata == 8'h00)
      else $error("identification visible with divisor set");

   chk_rx_target: assert property ( // [RULE4]
      s_rx_trig_write |=> receive_trigger_level == $past(bus.wdata[6:0])
                          && $stable(transmit_trigger_level))
      else $error("receive trigger write reached wrong level");

   chk_trg_hold: assert property ( // [RULE4]
      !wr_trg |=> $stable(receive_trigger_level)
                  && $stable(transmit_trigger_level))
      else $error("trigger level changed without write");

   chk_trg_no_echo: assert property ( // [RULE5]
      bus.wr && sel_trgfc |=> rdata == 8'h00)
      else $error("trigger write produced read data");

   chk_trg_unread: assert property ( // [RULE5]
      wr_trg |=> $stable(fc_sel_reg))
      else $error("trigger write moved level counter");

   chk_feature_control_table: assert property ( // [RULE8]
      wr_feature_control |=> trigger_table == $past(bus.wdata[5:4]))
      else $error("trigger table not stored");

   chk_table_hold: assert property ( // [RULE8]
      !wr_feature_control |=> $stable(trigger_table))
      else $error("trigger table changed without write");

   chk_feature_control_read: assert property ( // [RULE8]
      bus.rd && sel_feature_control |=> rdata[5:0] == $past(feature_control_reg))
      else $error("feature control read wrong");

   chk_hyst_lower: assert property ( // [RULE10]
      trigger_table == TABLE_D && !feature_control_reg[3]
      |-> rts_hysteresis == HYST_TABLE[feature_control_reg[3:0]])
      else $error("hysteresis wrong for lower codes");

   chk_hyst_upper: assert property ( // [RULE11]
      trigger_table == TABLE_D && feature_control_reg[3]
      |-> rts_hysteresis == HYST_TABLE[feature_control_reg[3:0]])
      else $error("hysteresis wrong for upper codes");

   chk_afr_write: assert property ( // [RULE12]
      wr_afr |=> afr_reg == $past(bus.wdata[AFR_OP2_BIT]))
      else $error("alternate function not stored");

   chk_op2_baud: assert property ( // [RULE13]
      !rst && afr_reg
      |=> multi_function_output == $past(baud_clock_output))
      else $error("multi-function output not baud clock");

   chk_asr_write: assert property ( // [RULE14]
      s_asr_write |=> asr_reg == $past(bus.wdata))
      else $error("advanced special not stored");

   chk_asr_read: assert property ( // [RULE14]
      bus.rd && sel_asr |=> rdata == $past(asr_reg))
      else $error("advanced special read wrong");

   chk_rs485_bit: assert property ( // [RULE15]
      s_asr_write |=> rs485_access_en == $past(bus.wdata[7]))
      else $error("RS-485 access enable wrong");

   chk_rx_disable: assert property ( // [RULE17]
      s_asr_write |=> rx_disable == $past(bus.wdata[5]))
      else $error("receiver disable wrong");

   chk_ir_mode: assert property ( // [RULE18]
      s_asr_write |=> ir_fast_mode == $past(bus.wdata[4]))
      else $error("infrared mode wrong");

   chk_ir_invert: assert property ( // [RULE19]
      s_asr_write |=> ir_rx_invert == $past(bus.wdata[3]))
      else $error("infrared polarity wrong");

   chk_sclk_access: assert property ( // [RULE20]
      s_asr_write |=> sample_clock_access_en == $past(bus.wdata[2]))
      else $error("sample clock access enable wrong");

   chk_fready_bit: assert property ( // [RULE21]
      s_asr_write |=> fifo_ready_access_dis == $past(bus.wdata[0]))
      else $error("FIFO ready access disable wrong");

   chk_afr_reserved: assert property ( // [RULE22]
      bus.rd && sel_afr |=> rdata[7:2] == 6'b00_0000 && !rdata[0])
      else $error("reserved alternate function bits not zero");

endmodule : uefr_top

`default_nettype wire

// [uefr_pkg.sv]
// Constants and types shared by the extended feature register block.
//------------------------------------------------------------------------
// Overview of operation
// RULE1: Second stop character RW only under key value.
// RULE2: Revision readable when divisor low byte zero.
// RULE3: Identification readable when both divisor bytes zero.
// RULE4: Trigger write bit 7 picks receive or transmit.
// RULE5: Trigger register write-only, levels 0 to 64.
// RULE6: Level counter read gives count and FIFO.
// RULE7: Level counter alternates FIFO after every read.
// RULE8: Feature control bits 5:4 choose trigger table.
// RULE9: Hysteresis code applies only with fourth table.
// RULE10: Codes 0 to 7 give 0..32 characters.
// RULE11: Codes 8 to 15 give 40..52, 12..36.
// RULE12: Alternate function needs feature bit 4 clear.
// RULE13: Alternate bit 1 picks multi-function output source.
// RULE14: Advanced special needs feature bit 4 set.
// RULE15: Advanced bit 7 enables RS-485 register access.
// RULE16: Advanced bit 6 disables the transmitter.
// RULE17: Advanced bit 5 disables the receiver.
// RULE18: Advanced bit 4 picks infrared pulse mode.
// RULE19: Advanced bit 3 inverts infrared receive input.
// RULE20: Advanced bit 2 enables sample clock access.
// RULE21: Advanced bit 0 disables FIFO ready access.
// RULE22: Reserved bits read zero, ignore writes; advanced special bit 1 is stored and read back.
//------------------------------------------------------------------------
package uefr_pkg;

   localparam logic [7:0] LCR_ENH_KEY   = 8'h00BF;
   localparam int         LCR_DLAB_BIT  = 7;
   localparam logic [7:0] DIV_ZERO      = 8'h0000;

   // Offsets while the line control register holds the key value.
   localparam logic [2:0] OFS_TRG_FC    = 3'h0;
   localparam logic [2:0] OFS_FEATURE_CONTROL      = 3'h1;
   localparam logic [2:0] OFS_SECOND_STOP_CHARACTER     = 3'h7;
   // Offsets while the divisor latch bit is set and the key is absent.
   localparam logic [2:0] OFS_REV       = 3'h0;
   localparam logic [2:0] OFS_DEVID     = 3'h1;
   localparam logic [2:0] OFS_AFR       = 3'h2;
   localparam logic [2:0] OFS_ASR       = 3'h4;

   localparam int         TRG_SEL_BIT   = 7;
   localparam int         FC_SEL_BIT    = 7;
   localparam int         AFR_OP2_BIT   = 1;
   localparam logic [1:0] TABLE_D       = 2'h3;

   localparam logic [7:0] SECOND_STOP_CHARACTER_RESET   = 8'h0000;
   localparam logic [6:0] TRIG_RESET    = 7'h00;
   localparam logic [5:0] FEATURE_CONTROL_RESET    = 6'h00;
   localparam logic       AFR_RESET     = 1'b0;

   typedef logic [5:0] uefr_hyst_t;

   // Hysteresis in characters, indexed by the four-bit code.
   localparam uefr_hyst_t HYST_TABLE [16] = '{
      6'd0,  6'd4,  6'd6,  6'd8,  6'd8,  6'd16, 6'd24, 6'd32,
      6'd40, 6'd44, 6'd48, 6'd52, 6'd12, 6'd20, 6'd28, 6'd36};

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } uefr_bus_t;

   typedef struct packed {
      logic rs485_acc;
      logic tx_dis;
      logic rx_dis;
      logic ir_fast;
      logic ir_inv;
      logic sclk_acc;
      logic spare;
      logic fready_dis;
   } uefr_asr_t;

   localparam uefr_asr_t ASR_RESET = 8'h0000;

endpackage : uefr_pkg

// [uefr_host.sv]
// Host processor model that drives the register port of the block.
`timescale 1ns/1ns
`default_nettype none

module uefr_host
(
   input  wire logic                mclk,
   output var  uefr_pkg::uefr_bus_t bus,
   input  wire logic [7:0]          rdata
);
   import uefr_pkg::*;

   initial bus = '0;

   // A one-cycle gap after each strobe keeps every drive unique per step.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus <= '0;
      #1;
   endtask : wr

   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus <= '0;
      #1 d = rdata;
   endtask : rd

endmodule : uefr_host

`default_nettype wire

// [testbench.sv]
// Self-checking testbench of the extended feature register block.
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, exp, got) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         $display("ERROR %s expected %h seen %h", nm, exp, got); \
         num_errors++; \
      end \
   end

module testbench;
   import uefr_pkg::*;

   localparam logic [7:0] REV_VAL = 8'h3C;  // Arbitrary value.
   localparam logic [7:0] ID_VAL  = 8'hC3;  // Arbitrary value.
   localparam int         LIMIT   = 2000;
   localparam logic [5:0] HYST_EXP [16] = '{0, 4, 6, 8, 8, 16, 24, 32,
                                            40, 44, 48, 52, 12, 20, 28, 36};

   logic       mclk = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] line_ctl = 8'h00;
   logic [7:0] div_lo = 8'h00;
   logic [7:0] div_hi = 8'h00;
   logic       feat4 = 1'b0;
   logic       mc3 = 1'b1;
   logic       baud = 1'b0;
   logic [6:0] rx_cnt = 7'h05;
   logic [6:0] tx_cnt = 7'h09;
   uefr_bus_t  bus;
   wire  [7:0] rdata, stop2, adv;
   wire  [6:0] rx_lvl, tx_lvl;
   wire  [5:0] hyst;
   wire  [1:0] tbl;
   wire        mfo;
   int         num_errors = 0;
   int         n_tests = 0;
   int         cycles = 0;

   uefr_host i_host (.mclk(mclk), .bus(bus), .rdata(rdata));

   uefr_top #(.REVISION(REV_VAL), .DEVICE_ID(ID_VAL)) i_dut (
      .mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata),
      .line_control_reg(line_ctl), .divisor_low_byte(div_lo),
      .divisor_high_byte(div_hi), .enhanced_feature_bit4(feat4),
      .modem_control_bit3(mc3), .baud_clock_output(baud),
      .rx_fifo_count(rx_cnt), .tx_fifo_count(tx_cnt),
      .second_stop_character(stop2), .receive_trigger_level(rx_lvl),
      .transmit_trigger_level(tx_lvl), .trigger_table(tbl),
      .rts_hysteresis(hyst), .multi_function_output(mfo),
      .rs485_access_en(adv[7]), .tx_disable(adv[6]), .rx_disable(adv[5]),
      .ir_fast_mode(adv[4]), .ir_rx_invert(adv[3]),
      .sample_clock_access_en(adv[2]), .fifo_ready_access_dis(adv[0]));

   assign adv[1] = 1'b0;

   always #5 mclk = ~mclk;

   // A hung handshake must still reach the verdict.
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         num_errors++;
         close_out();
      end
   end

   //---------------------------------------------------------------------
   // Helpers
   //---------------------------------------------------------------------
   task automatic close_out();
      if (num_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : close_out

   task automatic ctx(input logic [7:0] l, input logic [7:0] lo,
                      input logic [7:0] hi, input logic f);
      @(posedge mclk);
      line_ctl <= l;
      div_lo <= lo;
      div_hi <= hi;
      feat4 <= f;
   endtask : ctx

   task automatic rchk(input logic [2:0] a, input logic [7:0] e,
                       input string nm);
      logic [7:0] d;
      i_host.rd(a, d);
      `CHK(nm, e, d)
   endtask : rchk

   // The output pin is registered, so it lags the inputs by one cycle.
   task automatic pins(input logic b, input logic m);
      @(posedge mclk);
      baud <= b;
      mc3 <= m;
      repeat (2) @(posedge mclk);
      #1;
   endtask : pins

   //---------------------------------------------------------------------
   // Scenarios
   //---------------------------------------------------------------------
   task automatic t_reset();
      #1;
      `CHK("stop2_rst", 8'h00, stop2)
      `CHK("adv_rst", 8'h00, adv)
      `CHK("mfo_rst", 1'b1, mfo)
      ctx(8'h80, 8'h01, 8'h01, 1'b0);
      rchk(3'h2, 8'h00, "afr_rst");
      ctx(8'h80, 8'h01, 8'h01, 1'b1);
      rchk(3'h4, 8'h00, "asr_rst");
   endtask : t_reset

   task automatic t_stop2();
      ctx(8'hBF, 8'h01, 8'h01, 1'b0);
      i_host.wr(3'h7, 8'hA5);
      `CHK("stop2", 8'hA5, stop2)
      rchk(3'h7, 8'hA5, "stop2_rd");
      ctx(8'hBE, 8'h01, 8'h01, 1'b0);
      i_host.wr(3'h7, 8'h5A);
      `CHK("stop2_lock", 8'hA5, stop2)
      rchk(3'h7, 8'h00, "stop2_hid");
   endtask : t_stop2

   task automatic t_level();
      ctx(8'hBF, 8'h01, 8'h01, 1'b0);
      i_host.wr(3'h0, 8'hC0);
      `CHK("tx_lvl", 7'h40, tx_lvl)
      `CHK("rx_lvl0", 7'h00, rx_lvl)
      i_host.wr(3'h0, 8'h20);
      `CHK("rx_lvl", 7'h20, rx_lvl)
      `CHK("tx_keep", 7'h40, tx_lvl)
      rchk(3'h0, 8'h05, "fc_rx");
      rchk(3'h0, 8'h89, "fc_tx");
      rchk(3'h0, 8'h05, "fc_rx2");
   endtask : t_level

   task automatic t_feature_control();
      i_host.wr(3'h1, 8'hFF);
      rchk(3'h1, 8'h3F, "feature_control_rd");
      for (int c = 0; c < 16; c++)
      begin
         i_host.wr(3'h1, {4'h3, c[3:0]});
         `CHK("hyst", HYST_EXP[c], hyst)
      end
      i_host.wr(3'h1, 8'h27);
      `CHK("tbl", 2'h2, tbl)
      `CHK("hyst_off", 6'd0, hyst)
   endtask : t_feature_control

   task automatic t_ident();
      ctx(8'h80, 8'h00, 8'h01, 1'b0);
      rchk(3'h0, REV_VAL, "rev");
      rchk(3'h1, 8'h00, "id_hid");
      ctx(8'h80, 8'h00, 8'h00, 1'b0);
      rchk(3'h1, ID_VAL, "id");
      ctx(8'h80, 8'h01, 8'h00, 1'b0);
      rchk(3'h0, 8'h00, "rev_hid");
      ctx(8'h00, 8'h00, 8'h00, 1'b0);
      rchk(3'h0, 8'h00, "rev_off");
   endtask : t_ident

   task automatic t_afr();
      ctx(8'h80, 8'h01, 8'h01, 1'b0);
      i_host.wr(3'h2, 8'hFF);
      rchk(3'h2, 8'h02, "afr_rd");
      pins(1'b1, 1'b1);
      `CHK("mfo_baud1", 1'b1, mfo)
      pins(1'b0, 1'b1);
      `CHK("mfo_baud0", 1'b0, mfo)
      i_host.wr(3'h2, 8'h00);
      pins(1'b1, 1'b0);
      `CHK("mfo_mc", 1'b1, mfo)
      pins(1'b1, 1'b1);
      `CHK("mfo_mc1", 1'b0, mfo)
      ctx(8'h80, 8'h01, 8'h01, 1'b1);
      i_host.wr(3'h2, 8'h02);
      ctx(8'h80, 8'h01, 8'h01, 1'b0);
      rchk(3'h2, 8'h00, "afr_lock");
   endtask : t_afr

   task automatic t_asr(input logic [7:0] d);
      ctx(8'h80, 8'h01, 8'h01, 1'b1);
      i_host.wr(3'h4, d);
      `CHK("adv_hi", d[7:4], adv[7:4])
      `CHK("adv_mid", d[3:2], adv[3:2])
      `CHK("adv_lo", d[0], adv[0])
      rchk(3'h4, d, "asr_rd");
      ctx(8'h80, 8'h01, 8'h01, 1'b0);
      i_host.wr(3'h4, ~d);
      `CHK("adv_lock", d[7:2], adv[7:2])
   endtask : t_asr

   initial
   begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_stop2();
      t_level();
      t_feature_control();
      t_ident();
      t_afr();
      t_asr(8'hAD);
      t_asr(8'h52);
      close_out();
   end

endmodule : testbench

`default_nettype wire
